// *** hdl/gpio_pkg.sv ***
// constants for the four-port gpio block
package gpio_pkg;
  localparam int          ADDR_W      = 4;
  localparam int          PORT_W      = 8;
  localparam int          PE_W        = 3;
  localparam logic [3:0]  OFF_B_PIN   = 4'h0;
  localparam logic [3:0]  OFF_B_DIR   = 4'h1;
  localparam logic [3:0]  OFF_B_LAT   = 4'h2;
  localparam logic [3:0]  OFF_C_PIN   = 4'h3;
  localparam logic [3:0]  OFF_C_DIR   = 4'h4;
  localparam logic [3:0]  OFF_C_LAT   = 4'h5;
  localparam logic [3:0]  OFF_D_PIN   = 4'h6;
  localparam logic [3:0]  OFF_D_DIR   = 4'h7;
  localparam logic [3:0]  OFF_D_LAT   = 4'h8;
  localparam logic [3:0]  OFF_E_PIN   = 4'h9;
  localparam logic [3:0]  OFF_E_DIR   = 4'ha;
  localparam logic [3:0]  OFF_E_LAT   = 4'hb;
  localparam logic [7:0]  PORT_RST    = 8'h00;
  localparam logic [2:0]  PE_RST      = 3'h0;
  localparam int          BIT_RESET   = 0;
  localparam int          BIT_OSC_IN  = 1;
  localparam int          BIT_OSC_OUT = 2;
endpackage : gpio_pkg

// *** hdl/pin_sync.sv ***
// three-stage input synchroniser; a change counts once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset,
  // pins
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sync_out <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          sync_out[i] <= s3_q[i];
        end
      end
    end
  end
endmodule : pin_sync
`default_nettype wire

// *** hdl/gpio_ports.sv ***
// general-purpose i/o ports b, c, d and e with port e alternate functions
// Functional notes
// - crystal output mode takes port e pin 2 away from gpio.
// - port e pin 1 is oscillator input, no gpio, unless internal rc clock; then gpio.
// - pin 1 value override from compare b; pin 2 input disable from analog0.
// - reset-disable fuse programmed: port e pin 0 is ordinary gpio.
// - fuse unprogrammed: pin 0 belongs to reset circuitry, no gpio.
// - as reset pin, pin 0 direction, latch and input bits read zero.
// - ports b, c, d have 8-bit rw output latches resetting to zero.
// - ports b, c, d have 8-bit rw direction registers resetting to zero.
// - port e direction and latch: bits 2..0 rw, bits 7..3 read zero.
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
module gpio_ports #(
  parameter int PW = gpio_pkg::PORT_W
) (
  // clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        reset,
  // register port
  input  wire logic [gpio_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [7:0]                  reg_rdata,
  // configuration straps and peripheral signals
  input  wire logic                        reset_pin_disable_fuse,
  input  wire logic                        osc_output_pin_used,
  input  wire logic                        internal_rc_clock_sel,
  input  wire logic                        compare_b_output_enable,
  input  wire logic                        timer0_compare_b_out,
  input  wire logic                        analog0_digital_disable,
  // port b pins
  input  wire logic [PW-1:0]               port_b_in,
  output logic      [PW-1:0]               port_b_out,
  output logic      [PW-1:0]               port_b_oe,
  // port c pins
  input  wire logic [PW-1:0]               port_c_in,
  output logic      [PW-1:0]               port_c_out,
  output logic      [PW-1:0]               port_c_oe,
  // port d pins
  input  wire logic [PW-1:0]               port_d_in,
  output logic      [PW-1:0]               port_d_out,
  output logic      [PW-1:0]               port_d_oe,
  // port e pins
  input  wire logic [2:0]                  port_e_in,
  output logic      [2:0]                  port_e_out,
  output logic      [2:0]                  port_e_oe,
  // reset pin to reset circuitry
  output logic                             ext_reset_pin_level
);

  // pin synchronisers
  logic [PW-1:0] b_sync;
  logic [PW-1:0] c_sync;
  logic [PW-1:0] d_sync;
  logic [2:0]    e_sync;

  pin_sync #(.W(3*PW + 3)) u_sync (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in ({port_e_in, port_d_in, port_c_in, port_b_in}),
    .sync_out ({e_sync, d_sync, c_sync, b_sync})
  );

  // registers
  logic [PW-1:0] b_lat_q;
  logic [PW-1:0] b_dir_q;
  logic [PW-1:0] c_lat_q;
  logic [PW-1:0] c_dir_q;
  logic [PW-1:0] d_lat_q;
  logic [PW-1:0] d_dir_q;
  logic [2:0]    e_lat_q;
  logic [2:0]    e_dir_q;

  // pin 0 is the reset pin while the fuse is unprogrammed
  logic e0_is_reset;
  logic e1_is_clock;
  logic e2_is_clock;
  logic [2:0] e_gpio_ok;

  assign e0_is_reset = !reset_pin_disable_fuse;
  assign e1_is_clock = !internal_rc_clock_sel;
  assign e2_is_clock = osc_output_pin_used;
  assign e_gpio_ok   = {!e2_is_clock, !e1_is_clock, !e0_is_reset};

  // pin input write toggles the latch bits
  function automatic logic [7:0] wr_val(input logic [7:0] cur, input logic [7:0] wd,
                                        input logic is_pin);
    wr_val = is_pin ? (cur ^ wd) : wd;
  endfunction : wr_val

  // ports b, c, d
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      b_lat_q <= gpio_pkg::PORT_RST;
      b_dir_q <= gpio_pkg::PORT_RST;
      c_lat_q <= gpio_pkg::PORT_RST;
      c_dir_q <= gpio_pkg::PORT_RST;
      d_lat_q <= gpio_pkg::PORT_RST;
      d_dir_q <= gpio_pkg::PORT_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        gpio_pkg::OFF_B_PIN: b_lat_q <= wr_val(b_lat_q, reg_wdata, 1'b1);
        gpio_pkg::OFF_B_DIR: b_dir_q <= reg_wdata;
        gpio_pkg::OFF_B_LAT: b_lat_q <= reg_wdata;
        gpio_pkg::OFF_C_PIN: c_lat_q <= wr_val(c_lat_q, reg_wdata, 1'b1);
        gpio_pkg::OFF_C_DIR: c_dir_q <= reg_wdata;
        gpio_pkg::OFF_C_LAT: c_lat_q <= reg_wdata;
        gpio_pkg::OFF_D_PIN: d_lat_q <= wr_val(d_lat_q, reg_wdata, 1'b1);
        gpio_pkg::OFF_D_DIR: d_dir_q <= reg_wdata;
        gpio_pkg::OFF_D_LAT: d_lat_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // port e, only bits 2..0 are stored
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      e_lat_q <= gpio_pkg::PE_RST;
      e_dir_q <= gpio_pkg::PE_RST;
    end else if (reg_wr) begin
      if (reg_addr == gpio_pkg::OFF_E_PIN) begin
        e_lat_q <= e_lat_q ^ reg_wdata[2:0];
      end else if (reg_addr == gpio_pkg::OFF_E_DIR) begin
        e_dir_q <= reg_wdata[2:0];
      end else if (reg_addr == gpio_pkg::OFF_E_LAT) begin
        e_lat_q <= reg_wdata[2:0];
      end
    end
  end

  // port e input path; digital input of pin 2 disabled by analog0 bit
  logic [2:0] e_in_eff;
  assign e_in_eff = {e_sync[2] & !analog0_digital_disable, e_sync[1:0]};

  // port e read masking for reset pin
  logic [2:0] e_mask;
  assign e_mask = {2'b11, !e0_is_reset};

  // read data, one cycle after the strobe
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        gpio_pkg::OFF_B_PIN: reg_rdata <= b_sync;
        gpio_pkg::OFF_B_DIR: reg_rdata <= b_dir_q;
        gpio_pkg::OFF_B_LAT: reg_rdata <= b_lat_q;
        gpio_pkg::OFF_C_PIN: reg_rdata <= c_sync;
        gpio_pkg::OFF_C_DIR: reg_rdata <= c_dir_q;
        gpio_pkg::OFF_C_LAT: reg_rdata <= c_lat_q;
        gpio_pkg::OFF_D_PIN: reg_rdata <= d_sync;
        gpio_pkg::OFF_D_DIR: reg_rdata <= d_dir_q;
        gpio_pkg::OFF_D_LAT: reg_rdata <= d_lat_q;
        gpio_pkg::OFF_E_PIN: reg_rdata <= {5'h00, e_in_eff & e_mask};
        gpio_pkg::OFF_E_DIR: reg_rdata <= {5'h00, e_dir_q & e_mask};
        gpio_pkg::OFF_E_LAT: reg_rdata <= {5'h00, e_lat_q & e_mask};
        default:             reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // port e overrides: only pin 1 carries a value override
  logic [2:0] pin_value_override_enable;
  logic [2:0] pin_value_override_value;
  assign pin_value_override_enable = {1'b0, compare_b_output_enable, 1'b0};
  assign pin_value_override_value  = {1'b0, timer0_compare_b_out, 1'b0};

  // pin drivers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      port_b_out <= '0;
      port_b_oe  <= '0;
      port_c_out <= '0;
      port_c_oe  <= '0;
      port_d_out <= '0;
      port_d_oe  <= '0;
    end else begin
      port_b_out <= b_lat_q;
      port_b_oe  <= b_dir_q;
      port_c_out <= c_lat_q;
      port_c_oe  <= c_dir_q;
      port_d_out <= d_lat_q;
      port_d_oe  <= d_dir_q;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      port_e_out <= '0;
      port_e_oe  <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        // override value replaces latch; compare b needs dir bit 1 set
        port_e_out[i] <= pin_value_override_enable[i] ? pin_value_override_value[i]
                                                      : e_lat_q[i];
        port_e_oe[i]  <= e_dir_q[i] & e_gpio_ok[i];
      end
    end
  end

  // reset circuitry sees pin 0 only while it is the reset pin
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ext_reset_pin_level <= 1'b1;
    end else begin
      ext_reset_pin_level <= e0_is_reset ? e_sync[0] : 1'b1;
    end
  end

endmodule : gpio_ports
`default_nettype wire

// *** bench/gpio_ports_sva.sv ***
// assertion checker for the gpio ports block
`timescale 1ns/100ps
`default_nettype none
module gpio_ports_sva #(
  parameter int PW = 8
) (
  // clock, reset and register port
  input wire logic                        ref_clk,
  input wire logic                        reset,
  input wire logic [gpio_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0]                  reg_wdata,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire logic [7:0]                  reg_rdata,
  // straps, peripheral signals and pins
  input wire logic                        reset_pin_disable_fuse,
  input wire logic                        osc_output_pin_used,
  input wire logic                        internal_rc_clock_sel,
  input wire logic                        compare_b_output_enable,
  input wire logic                        timer0_compare_b_out,
  input wire logic [PW-1:0]               port_b_oe,
  input wire logic [2:0]                  port_e_out,
  input wire logic [2:0]                  port_e_oe,
  input wire logic                        ext_reset_pin_level
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  osc_out_free_a: assert property (osc_output_pin_used |=> !port_e_oe[2])
    else $error("pin e2 driven in crystal mode");
  osc_in_free_a: assert property (!internal_rc_clock_sel |=> !port_e_oe[1])
    else $error("pin e1 driven as clock input");
  cmp_override_a: assert property (internal_rc_clock_sel && compare_b_output_enable
    |=> port_e_out[1] == $past(timer0_compare_b_out)) else $error("pin e1 misses compare b");
  gpio_reset_a: assert property (reset_pin_disable_fuse |=> ext_reset_pin_level)
    else $error("reset level low with fuse programmed");
  reset_pin_a: assert property (!reset_pin_disable_fuse |=> !port_e_oe[0])
    else $error("reset pin driven");
  reset_read_a: assert property (reg_rd && !reset_pin_disable_fuse && reg_addr
    inside {4'h9, 4'ha, 4'hb} |=> !reg_rdata[0]) else $error("pin e0 bit reads one");
  e_upper_a: assert property (reg_rd && reg_addr inside {4'ha, 4'hb}
    |=> reg_rdata[7:3] == 5'h00) else $error("port e upper bits nonzero");
  b_dir_drive_a: assert property (reg_wr && reg_addr == gpio_pkg::OFF_B_DIR ##1
    !(reg_wr && reg_addr == gpio_pkg::OFF_B_DIR) |=> port_b_oe == $past(reg_wdata, 2))
    else $error("port b enables miss direction write");
endmodule : gpio_ports_sva
bind gpio_ports gpio_ports_sva #(.PW(PW)) chk_u (.ref_clk, .reset, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .reset_pin_disable_fuse, .osc_output_pin_used,
  .internal_rc_clock_sel, .compare_b_output_enable, .timer0_compare_b_out, .port_b_oe,
  .port_e_out, .port_e_oe, .ext_reset_pin_level);
`default_nettype wire

// *** bench/pin_model.sv ***
// pin level model: driven pins show the block's level, others the outside level
`timescale 1ns/100ps
`default_nettype none
module pin_model #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] ext_level,
  input  wire logic [W-1:0] drv_out,
  input  wire logic [W-1:0] drv_oe,
  output logic      [W-1:0] pin_level
);
  assign pin_level = (drv_oe & drv_out) | (~drv_oe & ext_level);
endmodule : pin_model
`default_nettype wire

// *** bench/tb_gpio_ports.sv ***
// self-checking bench for the gpio ports block
`timescale 1ns/100ps
`default_nettype none
module tb_gpio_ports;
  logic        ref_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rst_lvl;
  logic        fuse = 1'b1, osc = 1'b0, rc = 1'b1, cmp_en = 1'b0, cmp = 1'b0, adis = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata;
  logic [23:0] ext = 24'h0, pin_in, out_all, oe_all;
  logic [2:0]  ext_e = 3'h0, e_in, e_out, e_oe;
  int          miscompares = 0, total_checks = 0, cycles = 0;
  always #25 ref_clk = ~ref_clk;
  gpio_ports dut_u (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reset_pin_disable_fuse(fuse), .osc_output_pin_used(osc), .internal_rc_clock_sel(rc),
    .compare_b_output_enable(cmp_en), .timer0_compare_b_out(cmp),
    .analog0_digital_disable(adis), .port_b_in(pin_in[7:0]), .port_b_out(out_all[7:0]),
    .port_b_oe(oe_all[7:0]), .port_c_in(pin_in[15:8]), .port_c_out(out_all[15:8]),
    .port_c_oe(oe_all[15:8]), .port_d_in(pin_in[23:16]), .port_d_out(out_all[23:16]),
    .port_d_oe(oe_all[23:16]), .port_e_in(e_in), .port_e_out(e_out), .port_e_oe(e_oe),
    .ext_reset_pin_level(rst_lvl));
  pin_model #(.W(24)) bcd_u (.ext_level(ext), .drv_out(out_all), .drv_oe(oe_all),
    .pin_level(pin_in));
  pin_model #(.W(3)) e_u (.ext_level(ext_e), .drv_out(e_out), .drv_oe(e_oe), .pin_level(e_in));
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask : rd_chk
  task automatic settle;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask : settle
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    logic [7:0] d, l;
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < 12; i++)
      if (i % 3 != 0) rd_chk(4'(i), 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(4'(3 * i + 1), 8'h5a ^ 8'(i));
      wr(4'(3 * i + 2), 8'hc3 ^ 8'(i));
    end
    ext <= 24'h0f3c96;
    settle();
    for (int i = 0; i < 3; i++) begin
      d = 8'h5a ^ 8'(i);
      l = 8'hc3 ^ 8'(i);
      check(oe_all[8*i+:8], d);
      check(out_all[8*i+:8], l);
      rd_chk(4'(3 * i + 1), d);
      rd_chk(4'(3 * i + 2), l);
      rd_chk(4'(3 * i), (d & l) | (~d & ext[8*i+:8]));
    end
    $display("test ports b c d done");
    wr(gpio_pkg::OFF_E_DIR, 8'hff);
    wr(gpio_pkg::OFF_E_LAT, 8'hff);
    settle();
    rd_chk(gpio_pkg::OFF_E_DIR, 8'h07);
    rd_chk(gpio_pkg::OFF_E_LAT, 8'h07);
    check({5'h0, e_oe}, 8'h07);
    {cmp_en, cmp, adis} <= 3'b101;
    settle();
    check({5'h0, e_out}, 8'h05);
    rd_chk(gpio_pkg::OFF_E_PIN, 8'h01);
    cmp <= 1'b1;
    settle();
    check({5'h0, e_out}, 8'h07);
    rd_chk(gpio_pkg::OFF_E_PIN, 8'h03);
    {fuse, osc, rc} <= 3'b010;
    settle();
    check({5'h0, e_oe}, 8'h00);
    check({7'h0, rst_lvl}, 8'h00);
    rd_chk(gpio_pkg::OFF_E_DIR, 8'h06);
    rd_chk(gpio_pkg::OFF_E_LAT, 8'h06);
    ext_e <= 3'h1;
    settle();
    check({7'h0, rst_lvl}, 8'h01);
    rd_chk(gpio_pkg::OFF_E_PIN, 8'h00);
    {fuse, ext_e} <= {1'b1, 3'h0};
    settle();
    check({7'h0, rst_lvl}, 8'h01);
    rd_chk(gpio_pkg::OFF_E_DIR, 8'h07);
    $display("test port e done");
    wr(4'hc, 8'hff);
    for (int a = 12; a < 16; a++)
      rd_chk(4'(a), 8'h00);
    $display("test unmapped done");
    finish_test();
  end
endmodule : tb_gpio_ports
`default_nettype wire
